// ### hw/dic_pkg.sv
// Purpose: constants for the bus address, soft reset and output config bank
// Assumes: 8-bit registers reached through the serial control bus slave
// Notes:   offsets are register indices on the serial control bus
package dic_pkg;
    // register offsets
    localparam logic [7:0] DIC_OFF_BUS_ADDR  = 8'h00;
    localparam logic [7:0] DIC_OFF_SOFT_RST  = 8'h01;
    localparam logic [7:0] DIC_OFF_OUT_CFG   = 8'h02;

    // own_bus_address fields
    localparam int DIC_ADDR_SRC_BIT  = 0;
    localparam int DIC_ADDR_FIELD_LO = 1;

    // soft_reset_control fields
    localparam int DIC_RST_LOGIC_BIT = 0;
    localparam int DIC_RST_FULL_BIT  = 1;

    // output_behaviour_config fields
    localparam int DIC_CFG_SLEEP_BIT = 4;
    localparam int DIC_CFG_FBCLK_BIT = 5;
    localparam int DIC_CFG_OVR_BIT   = 6;
    localparam int DIC_CFG_OE_BIT    = 7;

    // reset values
    localparam logic       DIC_ADDR_SRC_RST = 1'b0;
    localparam logic [1:0] DIC_SOFT_RST_RST = 2'h0;
    localparam logic [3:0] DIC_OUT_CFG_RST  = 4'h0;
    localparam logic       DIC_OE_DEFAULT   = 1'b1;
    localparam logic       DIC_SLEEP_DEFAULT = 1'b1;

    // cycles after reset release before the strap is taken (synchroniser depth + margin)
    localparam logic [2:0] DIC_STRAP_SETTLE = 3'h5;
    // bits per bus byte
    localparam logic [3:0] DIC_BYTE_BITS    = 4'h8;

    typedef enum logic [3:0] {
        DIC_ST_IDLE,
        DIC_ST_ADDR,
        DIC_ST_ACK_ADDR,
        DIC_ST_PTR,
        DIC_ST_ACK_PTR,
        DIC_ST_WR,
        DIC_ST_ACK_WR,
        DIC_ST_RD,
        DIC_ST_ACK_RD
    } dic_state_t;
endpackage

// ### hw/dic_regbank.sv
// Purpose: bus address, soft reset and output config registers behind a bus slave
// Assumes: open-drain scl/sda sampled on clk; strap and lock are pins
// Notes:   register pointer auto-increments after each data byte
// Overview of operation
// [RULE_01] The own bus address sits in bits 7-1 and starts from the strap.
// [RULE_02] Bit 0 picks strap address (0) or the programmed address (1).
// [RULE_03] Writing bit 1 of the reset register resets everything and self-clears.
// [RULE_04] The full soft reset reloads strap-sourced fields from the strap.
// [RULE_05] Writing bit 0 of the reset register resets logic only and self-clears.
// [RULE_06] Config bit 6 lets the programmed enable and sleep values take effect.
// [RULE_07] Config bit 7 is output enable under override, else enable is 1.
// [RULE_08] Host software pulses the logic reset after raising output enable.
// [RULE_09] Config bit 5 with lock low puts the oscillator clock on the pixel clock.
// [RULE_10] Config bit 4 is the sleep state under override, else it is 1.
// [RULE_11] Reset bits 7-2 and config bits 3-0 are read-only zero.
// [RULE_12] Self-clearing bits are writable and return to zero after acting.
// [RULE_13] Reserved writes are dropped and reset bits read zero when done.
// [RULE_14] Power-on reset gives defaults and samples the strap at start-up.
`timescale 1ns/1ps
`default_nettype none
module dic_regbank
    import dic_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_o,
    output var  logic       sda_oe,
    input  wire logic [6:0] address_strap_pin,
    input  wire logic       link_lock,
    output var  logic       digital_reset,
    output var  logic       output_enable,
    output var  logic       sleep_state_choice,
    output var  logic       fallback_clock_sel
);
    logic [9:0] sync2;
    logic [9:0] sync3;
    logic [9:0] filt_q;
    logic       scl_p_q;
    logic       sda_p_q;
    logic [6:0] strap_q;
    logic [2:0] settle_q;
    logic       strap_done_q;
    logic [6:0] bus_address_field_q;
    logic       address_source_select_q;
    logic [1:0] soft_rst_q;
    logic [3:0] cfg_q;
    dic_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic       rw_q, rw_d;
    logic       nack_q, nack_d;
    logic       oe_q, oe_d;
    logic       wr_en;
    logic       digital_reset_q;
    logic       output_enable_q;
    logic       sleep_q;
    logic       fbclk_q;

    // pins through three flops
    // bus lines travel inverted so the all-zero chain reset reads as an idle bus
    dic_sync3 #(.WIDTH(10)) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({link_lock, address_strap_pin, ~sda_i, ~scl_i}),
        .stage2_q (sync2),
        .stage3_q (sync3)
    );

    // accept a level once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < 10; b++) begin : g_filt
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    filt_q[b] <= (b < 2) ? 1'b1 : 1'b0;
                end else if (sync2[b] == sync3[b]) begin
                    filt_q[b] <= (b < 2) ? ~sync3[b] : sync3[b];
                end
            end
        end
    endgenerate

    // bus events from filtered levels
    wire       scl_f     = filt_q[0];
    wire       sda_f     = filt_q[1];
    wire [6:0] strap_f   = filt_q[8:2];
    wire       lock_f    = filt_q[9];
    wire       scl_rise  = scl_f & ~scl_p_q;
    wire       scl_fall  = ~scl_f & scl_p_q;
    wire       start_ev  = scl_f & scl_p_q & ~sda_f & sda_p_q;
    wire       stop_ev   = scl_f & scl_p_q & sda_f & ~sda_p_q;
    wire       full_rst  = soft_rst_q[DIC_RST_FULL_BIT];
    wire       byte_done = scl_fall & (cnt_q == DIC_BYTE_BITS);

    // [RULE_02] address source select
    wire [6:0] eff_addr = address_source_select_q ? bus_address_field_q : strap_q;

    // read mux, reserved bits zero
    // [RULE_11] reserved read zero
    wire [7:0] rd_data =
        (ptr_q == DIC_OFF_BUS_ADDR) ? {bus_address_field_q, address_source_select_q} :
        (ptr_q == DIC_OFF_SOFT_RST) ? {6'h00, soft_rst_q} :
        (ptr_q == DIC_OFF_OUT_CFG)  ? {cfg_q, 4'h0} : 8'h00;

    // edge history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    // [RULE_14] strap taken after sync settles
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            settle_q     <= 3'h0;
            strap_done_q <= 1'b0;
            strap_q      <= 7'h00;
        end else if (!strap_done_q) begin
            settle_q <= settle_q + 3'h1;
            if (settle_q == DIC_STRAP_SETTLE) begin
                strap_done_q <= 1'b1;
                strap_q      <= strap_f;
            end
        end
    end

    // bus slave state machine
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        ptr_d   = ptr_q;
        rw_d    = rw_q;
        nack_d  = nack_q;
        oe_d    = oe_q;
        wr_en   = 1'b0;
        if (start_ev) begin
            state_d = DIC_ST_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
        end else if (stop_ev) begin
            state_d = DIC_ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                DIC_ST_ADDR, DIC_ST_PTR, DIC_ST_WR: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_f};
                        cnt_d   = cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_d = 4'h0;
                        if (state_q == DIC_ST_ADDR) begin
                            // [RULE_01] match own address
                            if (shift_q[7:1] == eff_addr) begin
                                state_d = DIC_ST_ACK_ADDR;
                                rw_d    = shift_q[0];
                                oe_d    = 1'b1;
                            end else begin
                                state_d = DIC_ST_IDLE;
                            end
                        end else if (state_q == DIC_ST_PTR) begin
                            ptr_d   = shift_q;
                            state_d = DIC_ST_ACK_PTR;
                            oe_d    = 1'b1;
                        end else begin
                            wr_en   = 1'b1;
                            state_d = DIC_ST_ACK_WR;
                            oe_d    = 1'b1;
                        end
                    end
                end
                DIC_ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            state_d = DIC_ST_RD;
                            shift_d = rd_data;
                            oe_d    = ~rd_data[7];
                        end else begin
                            state_d = DIC_ST_PTR;
                            oe_d    = 1'b0;
                        end
                    end
                end
                DIC_ST_ACK_PTR, DIC_ST_ACK_WR: begin
                    if (scl_fall) begin
                        oe_d    = 1'b0;
                        state_d = DIC_ST_WR;
                        if (state_q == DIC_ST_ACK_WR) begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                DIC_ST_RD: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_d   = 4'h0;
                        oe_d    = 1'b0;
                        ptr_d   = ptr_q + 8'h01;
                        state_d = DIC_ST_ACK_RD;
                    end else if (scl_fall) begin
                        shift_d = {shift_q[6:0], 1'b0};
                        oe_d    = ~shift_q[6];
                    end
                end
                DIC_ST_ACK_RD: begin
                    if (scl_rise) begin
                        nack_d = sda_f;
                    end
                    if (scl_fall) begin
                        if (nack_q) begin
                            state_d = DIC_ST_IDLE;
                        end else begin
                            state_d = DIC_ST_RD;
                            shift_d = rd_data;
                            oe_d    = ~rd_data[7];
                        end
                    end
                end
                default: begin
                    state_d = DIC_ST_IDLE;
                end
            endcase
        end
    end

    // slave state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= DIC_ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            ptr_q   <= ptr_d;
            rw_q    <= rw_d;
            nack_q  <= nack_d;
            oe_q    <= oe_d;
        end
    end

    // [RULE_04] strap reload on full reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_address_field_q     <= 7'h00;
            address_source_select_q <= DIC_ADDR_SRC_RST;
            cfg_q                   <= DIC_OUT_CFG_RST;
        end else if (full_rst || (!strap_done_q && settle_q == DIC_STRAP_SETTLE)) begin
            bus_address_field_q     <= full_rst ? strap_q : strap_f;
            address_source_select_q <= DIC_ADDR_SRC_RST;
            cfg_q                   <= DIC_OUT_CFG_RST;
        end else if (wr_en && ptr_q == DIC_OFF_BUS_ADDR) begin
            bus_address_field_q     <= shift_q[7:DIC_ADDR_FIELD_LO];
            address_source_select_q <= shift_q[DIC_ADDR_SRC_BIT];
        end else if (wr_en && ptr_q == DIC_OFF_OUT_CFG) begin
            // [RULE_13] reserved writes dropped
            cfg_q <= shift_q[7:4];
        end
    end

    // [RULE_12] self-clearing reset bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            soft_rst_q <= DIC_SOFT_RST_RST;
        end else if (wr_en && ptr_q == DIC_OFF_SOFT_RST) begin
            soft_rst_q <= shift_q[1:0];
        end else begin
            soft_rst_q <= 2'h0;
        end
    end

    // [RULE_05] pulse for either bit
    // [RULE_03] logic reset pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            digital_reset_q <= 1'b0;
        end else begin
            digital_reset_q <= |soft_rst_q;
        end
    end

    // [RULE_07] [RULE_09] [RULE_10] defaults and fallback
    // [RULE_06] override-steered outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            output_enable_q <= DIC_OE_DEFAULT;
            sleep_q         <= DIC_SLEEP_DEFAULT;
            fbclk_q         <= 1'b0;
        end else begin
            output_enable_q <= cfg_q[DIC_CFG_OVR_BIT-4] ? cfg_q[DIC_CFG_OE_BIT-4] : DIC_OE_DEFAULT;
            sleep_q         <= cfg_q[DIC_CFG_OVR_BIT-4] ? cfg_q[DIC_CFG_SLEEP_BIT-4]
                                                        : DIC_SLEEP_DEFAULT;
            fbclk_q         <= cfg_q[DIC_CFG_FBCLK_BIT-4] & ~lock_f;
        end
    end

    // outputs from flops, sda_o tied low
    assign sda_o              = 1'b0;
    assign sda_oe             = oe_q;
    assign digital_reset      = digital_reset_q;
    assign output_enable      = output_enable_q;
    assign sleep_state_choice = sleep_q;
    assign fallback_clock_sel = fbclk_q;

    // checks
    full_self_clr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
        full_rst |=> !full_rst ##1 !full_rst) else $error("full reset bit stuck");
    strap_reload_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
        full_rst |=> bus_address_field_q == strap_q && !address_source_select_q)
        else $error("strap not reloaded");
    logic_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
        soft_rst_q == 2'h1 |=> $stable(cfg_q) && $stable(bus_address_field_q) && digital_reset_q)
        else $error("logic reset touched registers");
    addr_src_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
        wr_en && ptr_q == DIC_OFF_BUS_ADDR && shift_q[0] |=> eff_addr == $past(shift_q[7:1]))
        else $error("programmed address not used");
    oe_force_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
        !cfg_q[2] |=> output_enable_q) else $error("enable not forced high");
    oe_ovr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        cfg_q[2] |=> output_enable_q == $past(cfg_q[3])) else $error("enable override lost");
    sleep_ovr_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_10]
        1'b1 |=> sleep_q == ($past(cfg_q[2]) ? $past(cfg_q[0]) : 1'b1))
        else $error("sleep select wrong");
    fb_clock_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_09]
        1'b1 |=> fbclk_q == ($past(cfg_q[1]) && !$past(lock_f))) else $error("fallback clock");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_11]
        rd_data[3:0] == 4'h0 || ptr_q == DIC_OFF_BUS_ADDR || ptr_q == DIC_OFF_SOFT_RST)
        else $error("reserved bits not zero");
    rst_read_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_13]
        |soft_rst_q |=> soft_rst_q == 2'h0 || $past(wr_en)) else $error("reset bit not cleared");
    pulse_once_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
        $rose(digital_reset_q) |=> !digital_reset_q) else $error("reset pulse too long");
endmodule
`default_nettype wire

// ### hw/dic_sync3.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   stage one feeds only stage two; callers compare stages two and three
`timescale 1ns/1ps
`default_nettype none
module dic_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] stage2_q,
    output var  logic [WIDTH-1:0] stage3_q
);
    logic [WIDTH-1:0] stage1_q;

    // one chain per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage1_q[i] <= 1'b0;
                    stage2_q[i] <= 1'b0;
                    stage3_q[i] <= 1'b0;
                end else begin
                    stage1_q[i] <= async_in[i];
                    stage2_q[i] <= stage1_q[i];
                    stage3_q[i] <= stage2_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### sim/deser_id_reset_output_cfg_bench.sv
// Purpose: self-checking bench for the address, soft reset and output config bank
// Assumes: host model drives the bus; strap and lock driven here
// Notes:   random values from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module deser_id_reset_output_cfg_bench
    import dic_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        scl_h;
    logic        sda_h;
    logic        sda_o;
    logic        sda_oe;
    logic [6:0]  strap = 7'h20;
    logic        link_lock = 1'b0;
    logic        digital_reset;
    logic        output_enable;
    logic        sleep_state_choice;
    logic        fallback_clock_sel;
    logic [31:0] rng = 32'h8A8D;
    int          err_total = 0;
    int          samples_checked = 0;
    int          pulses = 0;
    int          cycles = 0;
    logic [6:0]  home;
    logic [6:0]  prog;
    logic [7:0]  v;
    wire         sda_line = sda_h & (sda_oe ? sda_o : 1'b1);

    dic_host_model host (.clk(clk), .sda_line(sda_line), .scl_o(scl_h), .sda_o(sda_h));

    dic_regbank dut (.clk(clk), .reset_n(reset_n), .scl_i(scl_h), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .address_strap_pin(strap), .link_lock(link_lock),
        .digital_reset(digital_reset), .output_enable(output_enable),
        .sleep_state_choice(sleep_state_choice), .fallback_clock_sel(fallback_clock_sel));

    // clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end

    // soft reset pulse counter and hang limit
    always @(posedge clk) begin
        if (digital_reset === 1'b1) pulses <= pulses + 1;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            end_of_test();
        end
    end

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // expected {enable, sleep, fallback} from config and lock
    function automatic logic [2:0] outs(input logic [7:0] c, input logic lk);
        outs[2] = c[DIC_CFG_OVR_BIT] ? c[DIC_CFG_OE_BIT] : DIC_OE_DEFAULT;
        outs[1] = c[DIC_CFG_OVR_BIT] ? c[DIC_CFG_SLEEP_BIT] : DIC_SLEEP_DEFAULT;
        outs[0] = c[DIC_CFG_FBCLK_BIT] & ~lk;
    endfunction

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                      input logic chk);
        logic k0, k1, k2;
        host.start_cond();
        host.send_byte({a, 1'b0}, k0);
        host.send_byte(off, k1);
        host.send_byte(d, k2);
        host.stop_cond();
        if (chk) check("write ack", {7'h00, k0 & k1 & k2}, 8'h01);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] off, input logic [7:0] exp,
                      input logic want);
        logic k0, k1, k2;
        logic [7:0] d;
        d = 8'h00;
        host.start_cond();
        host.send_byte({a, 1'b0}, k0);
        host.send_byte(off, k1);
        host.start_cond();
        host.send_byte({a, 1'b1}, k2);
        if (k2) host.recv_byte(1'b0, d);
        host.stop_cond();
        check("read ack", {7'h00, k0 & k1 & k2}, {7'h00, want});
        if (want) check("read data", d, exp);
    endtask

    task automatic chk_outs(input logic [7:0] c);
        check("outputs", {5'h00, output_enable, sleep_state_choice, fallback_clock_sel},
              {5'h00, outs(c, link_lock)});
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        v = 8'(next_rand());
        home = {2'h1, v[4:0]};
        prog = home ^ 7'h10;
        strap = home;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (12) @(negedge clk);
        // defaults after power-on reset, unmapped offset reads zero
        chk_outs(8'h00);
        rd(home, DIC_OFF_BUS_ADDR, {home, 1'b0}, 1'b1);
        rd(home, DIC_OFF_SOFT_RST, 8'h00, 1'b1);
        rd(home, DIC_OFF_OUT_CFG, 8'h00, 1'b1);
        rd(home, 8'h03, 8'h00, 1'b1);
        $display("test defaults done");
        // address source select
        wr(home, DIC_OFF_BUS_ADDR, {prog, 1'b1}, 1'b1);
        rd(home, DIC_OFF_BUS_ADDR, 8'h00, 1'b0);
        rd(prog, DIC_OFF_BUS_ADDR, {prog, 1'b1}, 1'b1);
        wr(prog, DIC_OFF_BUS_ADDR, {prog, 1'b0}, 1'b1);
        rd(home, DIC_OFF_BUS_ADDR, {prog, 1'b0}, 1'b1);
        $display("test address done");
        // output config: corners then random, lock toggled
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h2F : 8'(next_rand());
            link_lock = rng[8];
            wr(home, DIC_OFF_OUT_CFG, v, 1'b1);
            repeat (10) @(negedge clk);
            chk_outs(v);
            link_lock = ~link_lock;
            repeat (10) @(negedge clk);
            chk_outs(v);
            rd(home, DIC_OFF_OUT_CFG, v & 8'hF0, 1'b1);
        end
        $display("test config done");
        // reserved reset bits
        wr(home, DIC_OFF_SOFT_RST, 8'hFC, 1'b1);
        rd(home, DIC_OFF_SOFT_RST, 8'h00, 1'b1);
        // enable raised then logic-only reset, registers kept
        wr(home, DIC_OFF_OUT_CFG, 8'h40, 1'b1);
        wr(home, DIC_OFF_OUT_CFG, 8'hC0, 1'b1);
        v = pulses[7:0];
        wr(home, DIC_OFF_SOFT_RST, 8'h01, 1'b1);
        repeat (10) @(negedge clk);
        check("pulses", pulses[7:0], v + 8'h01);
        rd(home, DIC_OFF_SOFT_RST, 8'h00, 1'b1);
        rd(home, DIC_OFF_OUT_CFG, 8'hC0, 1'b1);
        rd(home, DIC_OFF_BUS_ADDR, {prog, 1'b0}, 1'b1);
        $display("test logic reset done");
        // full reset reloads the captured strap, not the moved pin
        wr(home, DIC_OFF_BUS_ADDR, {prog, 1'b1}, 1'b1);
        wr(prog, DIC_OFF_OUT_CFG, 8'h70, 1'b1);
        strap = home ^ 7'h01;
        v = pulses[7:0];
        wr(prog, DIC_OFF_SOFT_RST, 8'h02, 1'b1);
        repeat (10) @(negedge clk);
        check("pulses", pulses[7:0], v + 8'h01);
        chk_outs(8'h00);
        rd(home, DIC_OFF_BUS_ADDR, {home, 1'b0}, 1'b1);
        rd(home, DIC_OFF_OUT_CFG, 8'h00, 1'b1);
        rd(home, DIC_OFF_SOFT_RST, 8'h00, 1'b1);
        $display("test full reset done");
        // power-on reset again takes the moved strap
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        chk_outs(8'h00);
        reset_n = 1'b1;
        repeat (12) @(negedge clk);
        rd(home ^ 7'h01, DIC_OFF_BUS_ADDR, {home ^ 7'h01, 1'b0}, 1'b1);
        rd(home ^ 7'h01, DIC_OFF_OUT_CFG, 8'h00, 1'b1);
        $display("test power-on reset done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ### sim/dic_host_model.sv
// Purpose: serial control bus master standing in for the host controller
// Assumes: scl and sda are open drain with pull-ups; 1 means released
// Notes:   changes lines only at the falling clk edge
`timescale 1ns/1ps
`default_nettype none
module dic_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output var  logic scl_o,
    output var  logic sda_o
);
    localparam int HALF = 16;

    // idle bus: both lines released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // wait a number of falling edges
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask

    // start, also serves as repeated start
    task automatic start_cond();
        gap(HALF / 2);
        sda_o = 1'b1;
        gap(HALF / 2);
        scl_o = 1'b1;
        gap(HALF);
        sda_o = 1'b0;
        gap(HALF);
        scl_o = 1'b0;
    endtask

    // stop: sda rises while scl high
    task automatic stop_cond();
        gap(HALF / 2);
        sda_o = 1'b0;
        gap(HALF / 2);
        scl_o = 1'b1;
        gap(HALF);
        sda_o = 1'b1;
        gap(HALF);
    endtask

    // one clock: data set mid-low, line read mid-high
    task automatic bit_xfer(input logic b, output logic seen);
        gap(HALF / 2);
        sda_o = b;
        gap(HALF / 2);
        scl_o = 1'b1;
        gap(HALF / 2);
        seen = sda_line;
        gap(HALF / 2);
        scl_o = 1'b0;
    endtask

    // byte out msb first, then the slave answer
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(v[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // byte in; ack when more bytes wanted, else nack
    task automatic recv_byte(input logic more, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            v[i] = s;
        end
        bit_xfer(~more, s);
    endtask
endmodule
`default_nettype wire
